// [inc/pme_pkg.sv]
// Constants, register map and state encodings of the power measurement engine.
// Assumes a single 25 MHz master clock and a plain word-addressed register port.
package pme_pkg;
  // Data widths: 24-bit fractions with 23 fraction bits, 48-bit sums.
  localparam int DW = 24;
  localparam int SW = 48;
  localparam int AW = 4;
  localparam int FRAC = 23;
  // Register indices on the plain register port.
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_CYCLE_COUNT = 4'h1;
  localparam logic [3:0] REG_VOLTAGE_GAIN = 4'h2;
  localparam logic [3:0] REG_CURRENT_GAIN = 4'h3;
  localparam logic [3:0] REG_VOLTAGE_OFFSET = 4'h4;
  localparam logic [3:0] REG_CURRENT_OFFSET = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  localparam logic [3:0] REG_MASK = 4'h7;
  localparam logic [3:0] REG_INST_VOLTAGE = 4'h8;
  localparam logic [3:0] REG_INST_CURRENT = 4'h9;
  localparam logic [3:0] REG_INST_POWER = 4'hA;
  localparam logic [3:0] REG_RMS_VOLTAGE = 4'hB;
  localparam logic [3:0] REG_RMS_CURRENT = 4'hC;
  localparam logic [3:0] REG_ACTIVE_POWER = 4'hD;
  localparam logic [3:0] REG_APPARENT_POWER = 4'hE;
  localparam logic [3:0] REG_CAL_PULSE_RATE = 4'hF;
  // Configuration fields.
  localparam int CLK_DIV_LSB = 0;
  localparam int CLK_DIV_W = 4;
  localparam int CURRENT_GAIN_SELECT_BIT = 4;
  localparam int VOLTAGE_HIGHPASS_ENABLE_BIT = 5;
  localparam int CURRENT_HIGHPASS_ENABLE_BIT = 6;
  localparam logic [23:0] CONFIG_WMASK = 24'h00007F;
  // Status and mask fields.
  localparam int SAMPLE_READY_FLAG_BIT = 0;
  localparam int CYCLE_READY_FLAG_BIT = 1;
  // Reset values.
  localparam logic [23:0] CONFIG_RESET = 24'h000001;
  localparam logic [23:0] CYCLE_COUNT_RESET = 24'h000FA0;
  localparam logic [23:0] GAIN_RESET = 24'h400000;
  localparam logic [15:0] CAL_PULSE_RATE_RESET = 16'h0100;
  localparam int GAIN_FRAC = 22;
  localparam int CAL_RATE_FRAC = 16;
  // Timing counts: modulator at 1/8 of the divided clock, words every 1024.
  localparam logic [2:0] MOD_LAST = 3'h7;
  localparam logic [6:0] DECIM_LAST = 7'h7F;
  // Filter shapes.
  localparam int IIR_STAGES = 4;
  localparam int IIR_SHIFT = 3;
  localparam int HPF_SHIFT = 10;
  localparam int HPF_FRAC = 8;
  // Front-end amplifier gain codes.
  localparam logic [5:0] VOLTAGE_PGA_GAIN = 6'h0A;
  localparam logic [5:0] CURRENT_PGA_GAIN_LOW = 6'h0A;
  localparam logic [5:0] CURRENT_PGA_GAIN_HIGH = 6'h32;
  // Saturation limits of a signed full-scale fraction.
  localparam logic signed [47:0] POS_LIMIT = 48'sh0000007FFFFF;
  localparam logic signed [47:0] NEG_LIMIT = 48'shFFFFFF800000;
  // Result engine states.
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_DIV = 4'b0010,
    S_SQRT = 4'b0100,
    S_MULT = 4'b1000
  } calc_state_e;
endpackage

// [design/power_measurement_engine.sv]
// Measurement engine: decimates two modulator bitstreams, calibrates them and
// computes instantaneous, RMS, active and apparent results with ready flags.
// Assumes the front end delivers one bit per channel on each modulator strobe.
//
// Behaviour
// - Voltage front end runs a fixed ten times amplification.
// - Current gain select bit picks ten times or fifty times.
// - Both modulators sample together at one eighth of the divided clock.
// - Each channel: third-order sinc decimation, then fourth-order compensation.
// - Separate enables switch a DC-removing high-pass into each path.
// - Filtered words get offset then gain; readouts return the result.
// - Sample rate is the clock over the divider over 1024.
// - A computation cycle spans N samples of the programmed cycle count.
// - RMS equals square root of summed squares over N, once per cycle.
// - Voltage times current gives power; its mean gives active power.
// - Apparent power is RMS voltage times RMS current, once per cycle.
// - Calibration pulse output rate is proportional to active power.
// - Reset leaves clock divider at one and cycle count at 4000.
// - Signed results span minus one to one, unsigned zero to one.
// - Largest result is two to the 23 minus one over that power.
// - Every sample sets the sample ready flag; interrupt if unmasked.
// - Every cycle end sets the cycle ready flag; interrupt if unmasked.
// - A set flag stays set until the host writes it to zero.
// - With cycle count one, cycle flag follows the sample flag.
// - With cycle count below two some calculations are skipped.
// - Voltage and current gain registers add up to four times gain.
module power_measurement_engine #(
  parameter int CAL_ACC_W = 28
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_addr,
  input wire logic [23:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_voltage_channel_input,
  input wire logic i_current_channel_input,
  output logic [23:0] o_rdata,
  output logic o_interrupt,
  output logic o_calibration_pulse_output_b,
  output logic o_modulator_strobe,
  output logic [5:0] o_voltage_pga_gain,
  output logic [5:0] o_current_pga_gain
);

  typedef struct packed {
    logic [23:0] rdata;
    logic [23:0] cfg;
    logic [23:0] ncyc;
    logic [1:0][23:0] gain;
    logic [1:0][23:0] off;
    logic [1:0] flags;
    logic [1:0] mask;
    logic [15:0] cal_rate;
    logic [3:0] kcnt;
    logic [2:0] mcnt;
    logic [6:0] dcnt;
    logic [1:0][2:0][23:0] integ;
    logic [1:0][2:0][23:0] cdly;
    logic [1:0][3:0][23:0] iir;
    logic [1:0][31:0] dc;
    logic [1:0][23:0] inst;
    logic [23:0] inst_p;
    logic samp;
    logic [47:0] acc_vv;
    logic [47:0] acc_ii;
    logic [47:0] acc_p;
    logic [23:0] scnt;
    pme_pkg::calc_state_e fsm;
    logic [1:0] job;
    logic [5:0] bitn;
    logic [2:0][47:0] work;
    logic psign;
    logic [47:0] quo;
    logic [24:0] rem;
    logic [2:0][23:0] mean;
    logic [23:0] root;
    logic [1:0][23:0] rms_new;
    logic [1:0][23:0] rms;
    logic [23:0] pact;
    logic [23:0] sapp;
    logic [CAL_ACC_W-1:0] cal_acc;
    logic cal_b;
    logic irq;
    logic mstb;
    logic [5:0] vpga;
    logic [5:0] cpga;
  } state_s;

  state_s q;
  state_s n;
  logic rst_meta_q;
  logic rst_sync_q;

  // Clamp a wide signed value to a 24-bit signed full-scale fraction.
  function automatic logic [23:0] sat24(input logic signed [47:0] v);
    if (v > pme_pkg::POS_LIMIT) begin
      return 24'h7FFFFF;
    end else if (v < pme_pkg::NEG_LIMIT) begin
      return 24'h800000;
    end
    return v[23:0];
  endfunction

  // Sign-extend a 24-bit fraction to the 48-bit working width.
  function automatic logic signed [47:0] sx(input logic [23:0] a);
    return 48'($signed(a));
  endfunction

  // Reset release is synchronised so that no flop leaves reset mid-edge.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Next-state logic of the whole engine.
  always_comb begin
    logic ktick;
    logic mtick;
    logic wtick;
    logic last;
    logic [1:0] in_bits;
    logic [1:0] clr;
    logic [1:0] set;
    logic [23:0] x;
    logic [23:0] step;
    logic [23:0] c0;
    logic [23:0] c1;
    logic [23:0] c2;
    logic [23:0] p24;
    logic [23:0] sq_v;
    logic [23:0] sq_i;
    logic [23:0] trial;
    logic [23:0] mag;
    logic [24:0] rem_s;
    logic [47:0] quo_s;
    logic [47:0] prod;
    logic [47:0] sum_p;
    logic signed [47:0] y;
    logic signed [31:0] e32;
    logic [CAL_ACC_W:0] cal_sum;
    ktick = 1'b0;
    mtick = 1'b0;
    wtick = 1'b0;
    last = 1'b0;
    in_bits = {i_current_channel_input, i_voltage_channel_input};
    clr = 2'h0;
    set = 2'h0;
    x = 24'h000000;
    step = 24'h000000;
    c0 = 24'h000000;
    c1 = 24'h000000;
    c2 = 24'h000000;
    p24 = 24'h000000;
    sq_v = 24'h000000;
    sq_i = 24'h000000;
    trial = 24'h000000;
    mag = 24'h000000;
    rem_s = 25'h0000000;
    quo_s = 48'h000000000000;
    prod = 48'h000000000000;
    sum_p = 48'h000000000000;
    y = 48'sh000000000000;
    e32 = 32'sh00000000;
    cal_sum = '0;
    n = q;
    n.samp = 1'b0;
    n.mstb = 1'b0;
    n.rdata = 24'h000000;

    // Divided clock, modulator phase and word phase counters.
    ktick = ({1'b0, q.kcnt} + 5'h01) >=
            {1'b0, q.cfg[pme_pkg::CLK_DIV_LSB +: pme_pkg::CLK_DIV_W]};
    n.kcnt = ktick ? 4'h0 : 4'(q.kcnt + 4'h1);
    if (ktick) begin
      n.mcnt = 3'(q.mcnt + 3'h1);
    end
    mtick = ktick && (q.mcnt == pme_pkg::MOD_LAST);
    wtick = mtick && (q.dcnt == pme_pkg::DECIM_LAST);

    // Both channels take their modulator bit on the same strobe.
    if (mtick) begin
      n.mstb = 1'b1;
      n.dcnt = 7'(q.dcnt + 7'h01);
      for (int ch = 0; ch < 2; ch++) begin
        step = in_bits[ch] ? 24'h000001 : 24'hFFFFFF;
        n.integ[ch][0] = q.integ[ch][0] + step;
        n.integ[ch][1] = q.integ[ch][1] + q.integ[ch][0];
        n.integ[ch][2] = q.integ[ch][2] + q.integ[ch][1];
      end
    end

    // Word path: comb, compensation, high-pass, offset, then gain.
    if (wtick) begin
      n.samp = 1'b1;
      for (int ch = 0; ch < 2; ch++) begin
        c0 = n.integ[ch][2] - q.cdly[ch][0];
        c1 = c0 - q.cdly[ch][1];
        c2 = c1 - q.cdly[ch][2];
        n.cdly[ch][0] = n.integ[ch][2];
        n.cdly[ch][1] = c0;
        n.cdly[ch][2] = c1;
        x = sat24(sx(c2) <<< 2);
        for (int s = 0; s < pme_pkg::IIR_STAGES; s++) begin
          y = sx(x) + ((sx(x) - sx(q.iir[ch][s])) >>> pme_pkg::IIR_SHIFT);
          x = sat24(y);
          n.iir[ch][s] = x;
        end
        if (q.cfg[pme_pkg::VOLTAGE_HIGHPASS_ENABLE_BIT + ch]) begin
          e32 = $signed({x, 8'h00}) - $signed(q.dc[ch]);
          n.dc[ch] = q.dc[ch] + 32'(e32 >>> pme_pkg::HPF_SHIFT);
          x = sat24(sx(x) - 48'($signed(q.dc[ch]) >>> pme_pkg::HPF_FRAC));
        end else begin
          n.dc[ch] = 32'h00000000;
        end
        x = sat24(sx(x) + sx(q.off[ch]));
        y = (sx(x) * $signed({24'h000000, q.gain[ch]})) >>> pme_pkg::GAIN_FRAC;
        n.inst[ch] = sat24(y);
      end
    end

    // Sample stage: power, squares, accumulation over the cycle.
    if (q.samp) begin
      prod = sx(q.inst[0]) * sx(q.inst[1]);
      p24 = sat24($signed(prod) >>> pme_pkg::FRAC);
      n.inst_p = p24;
      prod = sx(q.inst[0]) * sx(q.inst[0]);
      sq_v = prod[46:23];
      prod = sx(q.inst[1]) * sx(q.inst[1]);
      sq_i = prod[46:23];
      set[pme_pkg::SAMPLE_READY_FLAG_BIT] = 1'b1;
      // A zero cycle count never closes a cycle.
      last = (q.ncyc != 24'h000000) &&
             (({1'b0, q.scnt} + 25'h0000001) >= {1'b0, q.ncyc});
      if (last) begin
        n.work[0] = q.acc_vv + {24'h000000, sq_v};
        n.work[1] = q.acc_ii + {24'h000000, sq_i};
        sum_p = q.acc_p + sx(p24);
        n.psign = sum_p[47];
        n.work[2] = sum_p[47] ? 48'(-sum_p) : sum_p;
        n.acc_vv = 48'h000000000000;
        n.acc_ii = 48'h000000000000;
        n.acc_p = 48'h000000000000;
        n.scnt = 24'h000000;
        n.job = 2'h0;
        if (q.ncyc < 24'h000002) begin
          // Count of one: sums are the sample itself, division is skipped.
          n.mean[0] = n.work[0][23:0];
          n.mean[1] = n.work[1][23:0];
          n.mean[2] = n.work[2][23:0];
          n.root = 24'h000000;
          n.bitn = 6'h17;
          n.fsm = pme_pkg::S_SQRT;
        end else begin
          n.quo = n.work[0];
          n.rem = 25'h0000000;
          n.bitn = 6'h00;
          n.fsm = pme_pkg::S_DIV;
        end
      end else begin
        n.acc_vv = q.acc_vv + {24'h000000, sq_v};
        n.acc_ii = q.acc_ii + {24'h000000, sq_i};
        n.acc_p = q.acc_p + sx(p24);
        n.scnt = 24'(q.scnt + 24'h000001);
      end
    end

    // Result engine: divide three sums by N, two roots, one product.
    case (q.fsm)
      pme_pkg::S_IDLE: begin
      end
      pme_pkg::S_DIV: begin
        rem_s = {q.rem[23:0], q.quo[47]};
        quo_s = {q.quo[46:0], 1'b0};
        if (rem_s >= {1'b0, q.ncyc}) begin
          rem_s = rem_s - {1'b0, q.ncyc};
          quo_s[0] = 1'b1;
        end
        n.rem = rem_s;
        n.quo = quo_s;
        n.bitn = 6'(q.bitn + 6'h01);
        if (q.bitn == 6'h2F) begin
          n.mean[q.job] = (quo_s[47:24] != 24'h000000) ? 24'hFFFFFF :
                          quo_s[23:0];
          n.rem = 25'h0000000;
          n.bitn = 6'h00;
          if (q.job == 2'h2) begin
            n.job = 2'h0;
            n.root = 24'h000000;
            n.bitn = 6'h17;
            n.fsm = pme_pkg::S_SQRT;
          end else begin
            n.job = 2'(q.job + 2'h1);
            n.quo = q.work[2'(q.job + 2'h1)];
          end
        end
      end
      pme_pkg::S_SQRT: begin
        trial = q.root | (24'h000001 << q.bitn);
        prod = 48'(trial) * 48'(trial);
        if (prod <= {1'b0, q.mean[q.job], 23'h000000}) begin
          n.root = trial;
        end
        n.bitn = 6'(q.bitn - 6'h01);
        if (q.bitn == 6'h00) begin
          n.rms_new[q.job[0]] = n.root;
          n.root = 24'h000000;
          n.bitn = 6'h17;
          n.job = 2'h1;
          if (q.job != 2'h0) begin
            n.fsm = pme_pkg::S_MULT;
          end
        end
      end
      pme_pkg::S_MULT: begin
        // All cycle results change together so reads never mix cycles.
        prod = 48'(q.rms_new[0]) * 48'(q.rms_new[1]);
        n.sapp = prod[46:23];
        n.rms = q.rms_new;
        n.pact = sat24(q.psign ? -48'(q.mean[2]) : 48'(q.mean[2]));
        set[pme_pkg::CYCLE_READY_FLAG_BIT] = 1'b1;
        n.fsm = pme_pkg::S_IDLE;
      end
      default: begin
        n.fsm = pme_pkg::S_IDLE;
      end
    endcase

    // Register writes; a zero written to a status bit clears that flag.
    if (i_wr) begin
      case (i_addr)
        pme_pkg::REG_CONFIG: n.cfg = i_wdata & pme_pkg::CONFIG_WMASK;
        pme_pkg::REG_CYCLE_COUNT: n.ncyc = i_wdata;
        pme_pkg::REG_VOLTAGE_GAIN: n.gain[0] = i_wdata;
        pme_pkg::REG_CURRENT_GAIN: n.gain[1] = i_wdata;
        pme_pkg::REG_VOLTAGE_OFFSET: n.off[0] = i_wdata;
        pme_pkg::REG_CURRENT_OFFSET: n.off[1] = i_wdata;
        pme_pkg::REG_STATUS: clr = ~i_wdata[1:0];
        pme_pkg::REG_MASK: n.mask = i_wdata[1:0];
        pme_pkg::REG_CAL_PULSE_RATE: n.cal_rate = i_wdata[15:0];
        default: begin
        end
      endcase
    end

    // Register reads answer in the following cycle only.
    if (i_rd) begin
      case (i_addr)
        pme_pkg::REG_CONFIG: n.rdata = q.cfg;
        pme_pkg::REG_CYCLE_COUNT: n.rdata = q.ncyc;
        pme_pkg::REG_VOLTAGE_GAIN: n.rdata = q.gain[0];
        pme_pkg::REG_CURRENT_GAIN: n.rdata = q.gain[1];
        pme_pkg::REG_VOLTAGE_OFFSET: n.rdata = q.off[0];
        pme_pkg::REG_CURRENT_OFFSET: n.rdata = q.off[1];
        pme_pkg::REG_STATUS: n.rdata = {22'h000000, q.flags};
        pme_pkg::REG_MASK: n.rdata = {22'h000000, q.mask};
        pme_pkg::REG_INST_VOLTAGE: n.rdata = q.inst[0];
        pme_pkg::REG_INST_CURRENT: n.rdata = q.inst[1];
        pme_pkg::REG_INST_POWER: n.rdata = q.inst_p;
        pme_pkg::REG_RMS_VOLTAGE: n.rdata = q.rms[0];
        pme_pkg::REG_RMS_CURRENT: n.rdata = q.rms[1];
        pme_pkg::REG_ACTIVE_POWER: n.rdata = q.pact;
        pme_pkg::REG_APPARENT_POWER: n.rdata = q.sapp;
        pme_pkg::REG_CAL_PULSE_RATE: n.rdata = {8'h00, q.cal_rate};
        default: n.rdata = 24'h000000;
      endcase
    end

    // Set beats clear, so an event in the clearing cycle is kept.
    n.flags = (q.flags & ~clr) | set;
    n.irq = |(n.flags & n.mask);

    // Calibration pulses: a rate accumulator fed by active power magnitude.
    mag = q.pact[23] ? 24'(-q.pact) : q.pact;
    prod = 48'(mag) * 48'(q.cal_rate);
    cal_sum = {1'b0, q.cal_acc} +
              (CAL_ACC_W + 1)'(prod >> pme_pkg::CAL_RATE_FRAC);
    n.cal_acc = cal_sum[CAL_ACC_W-1:0];
    n.cal_b = ~cal_sum[CAL_ACC_W];

    // Amplifier gain codes driven to the analog front end.
    n.vpga = pme_pkg::VOLTAGE_PGA_GAIN;
    n.cpga = n.cfg[pme_pkg::CURRENT_GAIN_SELECT_BIT] ?
             pme_pkg::CURRENT_PGA_GAIN_HIGH :
             pme_pkg::CURRENT_PGA_GAIN_LOW;
  end

  // State register; reset loads the documented defaults.
  always_ff @(posedge i_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      q <= '0;
      q.cfg <= pme_pkg::CONFIG_RESET;
      q.ncyc <= pme_pkg::CYCLE_COUNT_RESET;
      q.gain[0] <= pme_pkg::GAIN_RESET;
      q.gain[1] <= pme_pkg::GAIN_RESET;
      q.cal_rate <= pme_pkg::CAL_PULSE_RATE_RESET;
      q.fsm <= pme_pkg::S_IDLE;
      q.cal_b <= 1'b1;
      q.vpga <= pme_pkg::VOLTAGE_PGA_GAIN;
      q.cpga <= pme_pkg::CURRENT_PGA_GAIN_LOW;
    end else begin
      q <= n;
    end
  end

  // Every output is a field of the state register.
  assign o_rdata = q.rdata;
  assign o_interrupt = q.irq;
  assign o_calibration_pulse_output_b = q.cal_b;
  assign o_modulator_strobe = q.mstb;
  assign o_voltage_pga_gain = q.vpga;
  assign o_current_pga_gain = q.cpga;

endmodule // power_measurement_engine

// [test/pme_assertions.sv]
// Port-level assertions for the power measurement engine.
// Assumes it is bound into the engine; it shadows only bus-written setup.
module pme_checker #(
  parameter int CAL_ACC_W = 28
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_addr,
  input wire logic [23:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [23:0] o_rdata,
  input wire logic o_interrupt,
  input wire logic o_calibration_pulse_output_b,
  input wire logic o_modulator_strobe,
  input wire logic [5:0] o_voltage_pga_gain,
  input wire logic [5:0] o_current_pga_gain
);
  logic [23:0] cfg_q;
  logic [23:0] cnt_q;
  logic [1:0] mask_q;
  logic wr_sm;
  logic k_one;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  // Shadow setup values; the engine's copies change on the same edge.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_q <= pme_pkg::CONFIG_RESET;
      cnt_q <= pme_pkg::CYCLE_COUNT_RESET;
      mask_q <= 2'h0;
    end else if (i_wr) begin
      if (i_addr == pme_pkg::REG_CONFIG) cfg_q <= i_wdata & 24'h00007F;
      if (i_addr == pme_pkg::REG_CYCLE_COUNT) cnt_q <= i_wdata;
      if (i_addr == pme_pkg::REG_MASK) mask_q <= i_wdata[1:0];
    end
  end

  // A status or mask write is the only legal way to drop the interrupt.
  assign wr_sm = i_wr && (i_addr == pme_pkg::REG_STATUS ||
    i_addr == pme_pkg::REG_MASK);
  assign k_one = cfg_q[3:0] == 4'h1;

  voltage_gain_fixed_a: assert property (
    o_voltage_pga_gain == 6'h0A)
    else $error("voltage amplifier code is not ten");
  current_gain_follow_a: assert property (
    i_wr && i_addr == pme_pkg::REG_CONFIG |-> ##2
    o_current_pga_gain == ($past(i_wdata[4], 2) ? 6'h32 : 6'h0A))
    else $error("current amplifier code does not follow select bit");
  strobe_spacing_a: assert property (
    o_modulator_strobe && k_one |=> !o_modulator_strobe [*7] ##1
    (o_modulator_strobe || !k_one))
    else $error("modulator strobe not every eight clocks");
  interrupt_masked_a: assert property (
    o_interrupt |-> mask_q != 2'h0)
    else $error("interrupt active with all flags masked");
  flag_holds_a: assert property (
    o_interrupt && !wr_sm |=> o_interrupt)
    else $error("interrupt dropped without a host write");
  config_readback_a: assert property (
    i_rd && i_addr == pme_pkg::REG_CONFIG |=> o_rdata == cfg_q)
    else $error("configuration readback wrong");
  count_readback_a: assert property (
    i_rd && i_addr == pme_pkg::REG_CYCLE_COUNT |=> o_rdata == cnt_q)
    else $error("cycle count readback wrong");
  mask_readback_a: assert property (
    i_rd && i_addr == pme_pkg::REG_MASK |=> o_rdata == {22'h0, mask_q})
    else $error("mask readback wrong");
  cal_pulse_width_a: assert property (
    $fell(o_calibration_pulse_output_b) |=> o_calibration_pulse_output_b)
    else $error("calibration pulse longer than one clock");
endmodule // pme_checker

bind power_measurement_engine pme_checker #(.CAL_ACC_W(CAL_ACC_W)) u_chk (
  .i_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .o_interrupt, .o_calibration_pulse_output_b, .o_modulator_strobe,
  .o_voltage_pga_gain, .o_current_pga_gain
);

// [test/afe_model.sv]
// Front-end model: two first-order sigma-delta modulators.
// Assumes the engine's strobe follows the edge that took the last bits.
module afe_model (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_strobe,
  input wire logic signed [7:0] i_v_level,
  input wire logic signed [7:0] i_i_level,
  output logic o_v_bit,
  output logic o_i_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  int v_acc;
  int i_acc;

  // New bits follow each strobe, so they settle long before the next take.
  // Level 64 is a full one density, minus 64 a full zero density.
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      v_acc = 0;
      i_acc = 0;
      o_v_bit <= 1'b0;
      o_i_bit <= 1'b0;
    end else if (i_strobe) begin
      v_acc = v_acc + i_v_level - (o_v_bit ? 64 : -64);
      i_acc = i_acc + i_i_level - (o_i_bit ? 64 : -64);
      o_v_bit <= v_acc >= 0;
      o_i_bit <= i_acc >= 0;
    end
  end
endmodule // afe_model

// [test/power_measurement_engine_tb.sv]
// Self-checking bench for the power measurement engine.
// Assumes the package is compiled first; one 25 MHz clock drives all.
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  err_count++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module power_measurement_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic rst_b;
  logic [3:0] addr;
  logic [23:0] wdata;
  logic wr_s;
  logic rd_s;
  logic vb;
  logic ib;
  logic [23:0] rdata;
  logic intr;
  logic cal_b;
  logic strobe;
  logic [5:0] vgain;
  logic [5:0] igain;
  logic signed [7:0] vlev;
  logic signed [7:0] ilev;
  logic [23:0] d;
  logic [23:0] a;
  logic [23:0] b;
  logic [3:0] regs [9] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'hF,
    4'hB, 4'hC, 4'hD, 4'hE};
  int cyc;
  int err_count;
  int total_checks;
  int p;
  int n;
  int rnd;

  power_measurement_engine DUT (
    .i_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_s), .i_rd(rd_s), .i_voltage_channel_input(vb),
    .i_current_channel_input(ib), .o_rdata(rdata), .o_interrupt(intr),
    .o_calibration_pulse_output_b(cal_b), .o_modulator_strobe(strobe),
    .o_voltage_pga_gain(vgain), .o_current_pga_gain(igain)
  );
  afe_model u_afe (
    .i_clk(clk), .i_rst_b(rst_b), .i_strobe(strobe), .i_v_level(vlev),
    .i_i_level(ilev), .o_v_bit(vb), .o_i_bit(ib)
  );

  // Filters and rounding blur results, so some checks allow a margin.
  function automatic logic close(input logic signed [31:0] x, y, t);
    return (x - y <= t) && (y - x <= t);
  endfunction

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Bus tasks start and end just after an edge; one idle cycle follows.
  task automatic wr(input logic [3:0] ad, input logic [23:0] dt);
    addr <= ad;
    wdata <= dt;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [3:0] ad);
    addr <= ad;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    d = rdata;
    @(posedge clk);
    #1;
  endtask

  task automatic wait_int(input logic lvl);
    n = 0;
    while (intr !== lvl && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(intr, lvl)
  endtask

  // Cycles between two unmasked flag indications, clearing in between.
  task automatic period(input logic [1:0] m);
    int t0;
    wr(pme_pkg::REG_MASK, {22'h0, m});
    wr(pme_pkg::REG_STATUS, 24'h0);
    wait_int(1'b0);
    wait_int(1'b1);
    t0 = cyc;
    wr(pme_pkg::REG_STATUS, 24'h0);
    wait_int(1'b0);
    wait_int(1'b1);
    p = cyc - t0;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Cycle ceiling that cuts a hang short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_count++;
      report_and_stop();
    end
  end

  initial begin
    {rst_b, addr, wdata, wr_s, rd_s, err_count, total_checks} = '0;
    vlev = 8'sd64;
    ilev = 8'sd64;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rnd = $urandom(32'hC7D9);
    rd(pme_pkg::REG_CONFIG);
    `CHK(d, 24'h000001)
    rd(pme_pkg::REG_CYCLE_COUNT);
    `CHK(d, 24'h000FA0)
    // Later scenarios use short counts only to keep the run brief.
    `CHK(d >= 24'h000FA0, 1'b1)
    // Random setup values read back; result registers ignore writes.
    foreach (regs[i]) begin
      b = 24'($urandom());
      wr(regs[i], b);
      rd(regs[i]);
      if (i < 5) `CHK(d, i == 4 ? b & 24'h00FFFF : b)
      else `CHK(d, 24'h0)
    end
    wr(pme_pkg::REG_VOLTAGE_GAIN, 24'h400000);
    wr(pme_pkg::REG_CURRENT_GAIN, 24'h400000);
    wr(pme_pkg::REG_VOLTAGE_OFFSET, 24'h0);
    wr(pme_pkg::REG_CURRENT_OFFSET, 24'h0);
    for (int g = 0; g < 2; g++) begin
      wr(pme_pkg::REG_CONFIG, 24'hFFFF81 | 24'(g << 4));
      `CHK(igain, g ? 6'h32 : 6'h0A)
      rd(pme_pkg::REG_CONFIG);
      `CHK(d, 24'h000001 | 24'(g << 4))
    end
    `CHK(vgain, 6'h0A)
    wr(pme_pkg::REG_CYCLE_COUNT, 24'h2);
    period(2'h1);
    `CHK(p, 1024)
    rd(pme_pkg::REG_MASK);
    `CHK(d, 24'h1)
    // Left uncleared across a sample, the flag must stay.
    repeat (1100) @(posedge clk);
    #1;
    `CHK(intr, 1'b1)
    rd(pme_pkg::REG_STATUS);
    `CHK(d[0], 1'b1)
    `CHK(d[23:2], 22'h0)
    period(2'h2);
    `CHK(p, 2048)
    period(2'h2);
    rd(pme_pkg::REG_RMS_VOLTAGE);
    a = d;
    rd(pme_pkg::REG_RMS_VOLTAGE);
    `CHK(d, a)
    `CHK(a[23], 1'b0)
    rd(pme_pkg::REG_RMS_CURRENT);
    b = d;
    rd(pme_pkg::REG_APPARENT_POWER);
    `CHK(close(d, 32'((48'(a) * 48'(b)) >> 23), 2), 1'b1)
    rd(pme_pkg::REG_INST_VOLTAGE);
    `CHK(close(d, a, 16), 1'b1)
    rd(pme_pkg::REG_ACTIVE_POWER);
    `CHK(d[23], 1'b0)
    b = d;
    wr(pme_pkg::REG_CAL_PULSE_RATE, 24'h00FFFF);
    n = 0;
    repeat (4096) begin
      @(posedge clk);
      #1;
      if (!cal_b) n++;
    end
    `CHK(close(n, 32'(((64'(b) * 64'hFFFF) >> 16) * 4096 >> 28), 2), 1'b1)
    ilev <= -8'sd64;
    repeat (2) period(2'h2);
    rd(pme_pkg::REG_ACTIVE_POWER);
    `CHK(d[23], 1'b1)
    wr(pme_pkg::REG_CYCLE_COUNT, 24'h1);
    period(2'h2);
    `CHK(p, 1024)
    vlev <= 8'sd4;
    repeat (4) period(2'h1);
    rd(pme_pkg::REG_INST_VOLTAGE);
    a = d;
    wr(pme_pkg::REG_VOLTAGE_GAIN, 24'h200000);
    wr(pme_pkg::REG_VOLTAGE_OFFSET, 24'h100000);
    period(2'h1);
    rd(pme_pkg::REG_INST_VOLTAGE);
    `CHK(close(d, (a + 24'h100000) / 2, a / 16), 1'b1)
    // With both high-pass filters on, steady DC must start to drain away.
    wr(pme_pkg::REG_CONFIG, 24'h000061);
    repeat (2) period(2'h1);
    rd(pme_pkg::REG_INST_VOLTAGE);
    a = d;
    rd(pme_pkg::REG_INST_CURRENT);
    b = d;
    period(2'h1);
    rd(pme_pkg::REG_INST_VOLTAGE);
    `CHK(d < a, 1'b1)
    rd(pme_pkg::REG_INST_CURRENT);
    `CHK($signed(d) > $signed(b), 1'b1)
    wr(pme_pkg::REG_CONFIG, 24'h000012);
    period(2'h1);
    `CHK(p, 2048)
    report_and_stop();
  end
endmodule // power_measurement_engine_tb
